// *** include/acs_pkg.sv ***
// package for the single channel converter control block
package acs_pkg;
  // register addresses (word index times four)
  localparam logic [7:0] ADDR_CONV_CTRL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONV_CONTROL     = 8'h04;
  localparam logic [7:0] ADDR_CONV_CONTROL_TWO = 8'h08;
  localparam logic [7:0] ADDR_RESULT_A         = 8'h0c;
  localparam logic [7:0] ADDR_WRITE_PROTECT    = 8'h10;
  localparam logic [7:0] ADDR_MODULE_STOP      = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS       = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ENABLE       = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_CLEAR        = 8'h20;
  // ctrl/status fields
  localparam int CH_LSB    = 0;
  localparam int START_BIT = 5;
  localparam int IE_BIT    = 6;
  // control, control two and module stop fields
  localparam int MODE_LSB  = 0;
  localparam int CKS_LSB   = 2;
  localparam int TRIGGER_SOURCE_SELECT_LSB  = 4;
  localparam int ALIGNMENT_SELECT_BIT = 0;
  localparam int STOP_BIT  = 0;
  // field values
  localparam logic [2:0] CH_AN0      = 3'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] CKS_DIV2    = 2'h2;
  localparam logic [2:0] TRIGGER_SOURCE_SELECT_TIMER  = 3'h1;
  localparam logic [2:0] TRIGGER_SOURCE_SELECT_SW     = 3'h0;
  localparam logic [15:0] PROT_KEY_OPEN  = 16'ha502;
  localparam logic [15:0] PROT_KEY_CLOSE = 16'ha500;
  localparam logic [15:0] PROT_OPEN_MASK = 16'h0002;
  // conversion timing: one cycle per bit plus sampling, in conversion clocks
  localparam int RES_BITS = 10;
  localparam logic [4:0] CONV_CLKS = 5'd12;
  localparam logic [4:0] CONV_LAST = CONV_CLKS - 5'd1;
  localparam logic [3:0] DIV_ONE   = 4'h0;
  localparam logic [3:0] DIV_TWO   = 4'h1;
  localparam logic [3:0] DIV_FOUR  = 4'h3;
  localparam logic [3:0] DIV_EIGHT = 4'h7;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } acs_bus_req_t;

  typedef struct packed {
    logic [2:0] channel_select;
    logic       conversion_start_bit;
    logic       conv_end_irq_enable;
    logic [1:0] mode;
    logic [1:0] clock_select;
    logic [2:0] trigger_source_select;
    logic       alignment_select;
  } acs_cfg_t;

  typedef enum logic [2:0] {
    ST_STOPPED = 3'b001,
    ST_IDLE    = 3'b010,
    ST_CONV    = 3'b100
  } acs_state_t;
endpackage

// *** src/acs_ctrl.sv ***
// single channel converter control: registers, trigger, sequencing, irq
`timescale 1ns/100ps
`default_nettype none
module acs_ctrl
  import acs_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // timer trigger and analog sample
  input  wire logic        i_timer_cmp_a,
  input  wire logic [9:0]  i_sample_data,
  output logic      [2:0]  o_sample_channel,
  // interrupt
  output logic             o_conv_end_interrupt,
  output logic             o_irq
);
  acs_bus_req_t req;
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  acs_cfg_t   cfg_q;
  acs_state_t state_q, state_d;
  logic [15:0] prot_q;
  logic        stop_q;
  logic [15:0] result_a_q;
  logic [3:0]  div_q;
  logic [4:0]  cnt_q;
  logic        irq_pulse_q;
  logic        sts_q, ien_q;
  logic [31:0] rdata_q;
  logic [2:0]  trg_sync_q;
  logic        trg_seen_q;

  // decode
  wire wr_csr  = req.wr && req.addr == ADDR_CONV_CTRL_STATUS && !stop_q;
  wire wr_cr   = req.wr && req.addr == ADDR_CONV_CONTROL && !stop_q;
  wire wr_cr2  = req.wr && req.addr == ADDR_CONV_CONTROL_TWO && !stop_q;
  wire wr_prot = req.wr && req.addr == ADDR_WRITE_PROTECT;
  wire wr_stop = req.wr && req.addr == ADDR_MODULE_STOP && (prot_q & PROT_OPEN_MASK) != 16'h0;
  wire wr_ien  = req.wr && req.addr == ADDR_IRQ_ENABLE;
  wire wr_iclr = req.wr && req.addr == ADDR_IRQ_CLEAR;

  // timer trigger: three-flop sync, change accepted when stages two and three agree
  wire trg_level = trg_sync_q[1] & trg_sync_q[2];
  wire trg_rise  = trg_level & ~trg_seen_q;
  wire trg_sel   = cfg_q.trigger_source_select == TRIGGER_SOURCE_SELECT_TIMER;
  wire hw_start  = trg_rise && trg_sel && cfg_q.conversion_start_bit;
  wire sw_start  = wr_csr && i_wdata[START_BIT] && !cfg_q.conversion_start_bit
                   && cfg_q.trigger_source_select == TRIGGER_SOURCE_SELECT_SW;
  wire go        = (state_q == ST_IDLE) && (hw_start || sw_start);

  // conversion clock divider
  logic [3:0] div_max;
  always_comb begin
    case (cfg_q.clock_select)
      2'h0:    div_max = DIV_EIGHT;
      2'h1:    div_max = DIV_FOUR;
      2'h2:    div_max = DIV_TWO;
      default: div_max = DIV_ONE;
    endcase
  end
  wire conv_tick = (div_q == div_max);
  wire conv_done = (state_q == ST_CONV) && conv_tick && (cnt_q == CONV_LAST);
  wire run_ok    = cfg_q.mode == MODE_SINGLE;

  // result alignment
  wire [15:0] res_left  = {i_sample_data, 6'h00};
  wire [15:0] res_right = {6'h00, i_sample_data};
  wire [15:0] res_fmt   = cfg_q.alignment_select ? res_left : res_right;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STOPPED: if (!stop_q) state_d = ST_IDLE;
      ST_IDLE: begin
        if (stop_q) state_d = ST_STOPPED;
        else if (go && run_ok) state_d = ST_CONV;
      end
      ST_CONV: begin
        if (stop_q || !cfg_q.conversion_start_bit) state_d = ST_IDLE;
        else if (conv_done) state_d = ST_IDLE;
      end
      default: state_d = ST_STOPPED;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_STOPPED;
      stop_q  <= 1'b1;
      prot_q  <= 16'h0;
    end else begin
      state_q <= state_d;
      if (wr_prot) prot_q <= i_wdata[15:0];
      if (wr_stop) stop_q <= i_wdata[STOP_BIT];
    end
  end

  // configuration registers
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cfg_q <= '0;
    end else begin
      if (wr_csr) begin
        cfg_q.channel_select       <= i_wdata[CH_LSB +: 3];
        cfg_q.conversion_start_bit <= i_wdata[START_BIT];
        cfg_q.conv_end_irq_enable  <= i_wdata[IE_BIT];
      end
      if (wr_cr) begin
        cfg_q.mode                  <= i_wdata[MODE_LSB +: 2];
        cfg_q.clock_select          <= i_wdata[CKS_LSB +: 2];
        cfg_q.trigger_source_select <= i_wdata[TRIGGER_SOURCE_SELECT_LSB +: 3];
      end
      if (wr_cr2) cfg_q.alignment_select <= i_wdata[ALIGNMENT_SELECT_BIT];
    end
  end

  // conversion engine
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || state_q != ST_CONV) begin
      div_q <= 4'h0;
      cnt_q <= 5'h0;
    end else begin
      div_q <= conv_tick ? 4'h0 : div_q + 4'h1;
      if (conv_tick) cnt_q <= cnt_q + 5'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      result_a_q  <= 16'h0;
      irq_pulse_q <= 1'b0;
    end else begin
      irq_pulse_q <= conv_done && cfg_q.conv_end_irq_enable;
      if (conv_done && cfg_q.channel_select == CH_AN0) result_a_q <= res_fmt;
    end
  end

  // trigger sync and edge memory
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      trg_sync_q <= 3'h0;
      trg_seen_q <= 1'b0;
    end else begin
      trg_sync_q <= {trg_sync_q[1:0], i_timer_cmp_a};
      if (trg_sync_q[1] == trg_sync_q[2]) trg_seen_q <= trg_level;
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sts_q <= 1'b0;
      ien_q <= 1'b0;
    end else begin
      if (wr_ien) ien_q <= i_wdata[0];
      if (conv_done) sts_q <= 1'b1;
      else if (wr_iclr && i_wdata[0]) sts_q <= 1'b0;
    end
  end

  // read data
  logic [31:0] rmux;
  always_comb begin
    case (req.addr)
      ADDR_CONV_CTRL_STATUS: rmux = {25'h0, cfg_q.conv_end_irq_enable,
                                     cfg_q.conversion_start_bit, 2'h0, cfg_q.channel_select};
      ADDR_CONV_CONTROL:     rmux = {25'h0, cfg_q.trigger_source_select,
                                     cfg_q.clock_select, cfg_q.mode};
      ADDR_CONV_CONTROL_TWO: rmux = {31'h0, cfg_q.alignment_select};
      ADDR_RESULT_A:         rmux = {16'h0, result_a_q};
      ADDR_WRITE_PROTECT:    rmux = {16'h0, prot_q};
      ADDR_MODULE_STOP:      rmux = {31'h0, stop_q};
      ADDR_IRQ_STATUS:       rmux = {30'h0, state_q == ST_CONV, sts_q};
      ADDR_IRQ_ENABLE:       rmux = {31'h0, ien_q};
      default:               rmux = 32'h0;
    endcase
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) rdata_q <= 32'h0;
    else rdata_q <= req.rd ? rmux : 32'h0;
  end

  assign o_rdata              = rdata_q;
  assign o_sample_channel     = cfg_q.channel_select;
  assign o_conv_end_interrupt = irq_pulse_q;
  assign o_irq                = sts_q & ien_q;

  // cycles spent in the running conversion, watched by the length checks
  localparam logic [7:0] AGE_DIV2_LAST = {3'h0, CONV_CLKS} + {3'h0, CONV_CLKS} - 8'h1;
  logic [7:0] conv_age_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || state_q != ST_CONV) conv_age_q <= 8'h0;
    else conv_age_q <= conv_age_q + 8'h1;
  end

  // checks
  chk_stop_locks_cfg: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    stop_q && req.wr && (req.addr == ADDR_CONV_CTRL_STATUS || req.addr == ADDR_CONV_CONTROL
    || req.addr == ADDR_CONV_CONTROL_TWO) |=> $stable(cfg_q))
    else $error("config changed while stopped");
  chk_conv_length: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    conv_done && cfg_q.clock_select == CKS_DIV2 |-> conv_age_q == AGE_DIV2_LAST)
    else $error("conversion length wrong at divide by two");
  chk_end_pulse: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    conv_done && cfg_q.conv_end_irq_enable |=> o_conv_end_interrupt)
    else $error("missing end request");
  chk_auto_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_conv_end_interrupt |=> !o_conv_end_interrupt)
    else $error("end flag did not self clear");
  chk_irq_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_conv_end_interrupt |-> $past(cfg_q.conv_end_irq_enable))
    else $error("end request while disabled");
  chk_left_just: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    conv_done && cfg_q.alignment_select && cfg_q.channel_select == CH_AN0
    |=> result_a_q[5:0] == 6'h0 && result_a_q[15:6] == $past(i_sample_data))
    else $error("result not left justified");
  chk_start_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    state_q == ST_CONV && !cfg_q.conversion_start_bit |=> state_q == ST_IDLE)
    else $error("did not stop on start clear");
  chk_no_retrig: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    state_q == ST_CONV && hw_start && cnt_q != 5'h0 |=> cnt_q != 5'h0 || state_q != ST_CONV)
    else $error("trigger restarted conversion");
  chk_timer_only: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(state_q == ST_CONV) && cfg_q.trigger_source_select == TRIGGER_SOURCE_SELECT_TIMER
    |-> $past(trg_rise))
    else $error("timer mode started without trigger");
  chk_trig_start: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    state_q == ST_IDLE && hw_start && run_ok && !stop_q |=> state_q == ST_CONV)
    else $error("timer trigger did not start conversion");
  chk_sw_start: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    state_q == ST_IDLE && sw_start && run_ok |=> state_q == ST_CONV)
    else $error("start bit did not start conversion");
  chk_idle_no_start: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    state_q == ST_IDLE && !cfg_q.conversion_start_bit && !wr_csr |=> state_q != ST_CONV)
    else $error("conversion started while start bit clear");
  chk_retrig_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    state_q == ST_CONV && hw_start && !conv_done && cfg_q.conversion_start_bit && !stop_q
    |=> state_q == ST_CONV && conv_age_q == $past(conv_age_q) + 8'h1)
    else $error("trigger disturbed running conversion");

  chk_single_conv: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    conv_done |=> state_q == ST_IDLE)
    else $error("conversion did not stop after one result");
  chk_end_idle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_conv_end_interrupt |-> state_q == ST_IDLE)
    else $error("end request while converter not idle");
  chk_status_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    conv_done |=> sts_q)
    else $error("status not set at conversion end");
  chk_sticky_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    sts_q && !(wr_iclr && i_wdata[0]) |=> sts_q)
    else $error("status dropped without clear");
  chk_irq_quiet: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    conv_done && !cfg_q.conv_end_irq_enable |=> !o_conv_end_interrupt)
    else $error("end request raised while disabled");
  chk_result_right: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    conv_done && !cfg_q.alignment_select && cfg_q.channel_select == CH_AN0
    |=> result_a_q == {6'h0, $past(i_sample_data)})
    else $error("result not right justified");
  chk_other_chan: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    conv_done && cfg_q.channel_select != CH_AN0 |=> $stable(result_a_q))
    else $error("other channel wrote result a");

  chk_stop_reset: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $fell(i_sys_rst) |-> stop_q && state_q == ST_STOPPED)
    else $error("module not stopped after reset");
  chk_stopped_idle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    stop_q |=> state_q != ST_CONV)
    else $error("conversion while stopped");
  chk_stop_protect: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    req.wr && req.addr == ADDR_MODULE_STOP && (prot_q & PROT_OPEN_MASK) == 16'h0
    |=> $stable(stop_q))
    else $error("stop bit changed while protected");

  // scenario covers
  cov_conv_done: cover property (@(posedge i_ref_clk) conv_done);
  cov_irq: cover property (@(posedge i_ref_clk) o_irq);
  cov_retrig: cover property (@(posedge i_ref_clk) state_q == ST_CONV && hw_start);
  cov_sw_start: cover property (@(posedge i_ref_clk) state_q == ST_IDLE && sw_start);
  cov_right_align: cover property (@(posedge i_ref_clk) conv_done && !cfg_q.alignment_select);
endmodule
`default_nettype wire

// *** verif/acs_timer_model.sv ***
// timer compare-match source and analog sample source for the converter control
`timescale 1ns/100ps
`default_nettype none
module acs_timer_model
  import acs_pkg::*;
(
  // clock
  input  wire logic       i_ref_clk,
  // bench command
  input  wire logic       i_fire,
  input  wire logic [9:0] i_level,
  // converter side
  output logic            o_timer_cmp_a,
  output logic      [9:0] o_sample_data
);
  logic [2:0] hold_q;
  initial hold_q = 3'h0;
  // match held four cycles so the input synchroniser sees it; bench sets the period
  always @(posedge i_ref_clk) begin
    if (i_fire) hold_q <= 3'h4;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
  end
  assign o_timer_cmp_a = (hold_q != 3'h0);
  assign o_sample_data = i_level;
endmodule
`default_nettype wire

// *** verif/acs_ctrl_bench.sv ***
// self-checking bench for the single channel converter control
`timescale 1ns/100ps
`default_nettype none
module acs_ctrl_bench
  import acs_pkg::*;
  ;
  logic        ref_clk;
  logic        sys_rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [31:0] rdata;
  logic        fire;
  logic [9:0]  level;
  logic        cmp_a;
  logic [9:0]  sample;
  logic [2:0]  chan;
  logic        cei;
  logic        irq;
  logic [31:0] cfg;
  logic [31:0] ctl;
  logic [31:0] ctl_noie;
  int          failures;
  int          checks;

  assign cfg = ({30'h0, CKS_DIV2} << CKS_LSB) | ({29'h0, TRIGGER_SOURCE_SELECT_TIMER} << TRIGGER_SOURCE_SELECT_LSB)
             | ({30'h0, MODE_SINGLE} << MODE_LSB);
  assign ctl_noie = (32'h1 << START_BIT) | ({29'h0, CH_AN0} << CH_LSB);
  assign ctl = ctl_noie | (32'h1 << IE_BIT);

  acs_ctrl uut (
    .i_ref_clk            (ref_clk),
    .i_sys_rst            (sys_rst),
    .i_addr               (addr),
    .i_wdata              (wdata),
    .i_wr                 (wr_s),
    .i_rd                 (rd_s),
    .o_rdata              (rdata),
    .i_timer_cmp_a        (cmp_a),
    .i_sample_data        (sample),
    .o_sample_channel     (chan),
    .o_conv_end_interrupt (cei),
    .o_irq                (irq)
  );

  acs_timer_model far (
    .i_ref_clk     (ref_clk),
    .i_fire        (fire),
    .i_level       (level),
    .o_timer_cmp_a (cmp_a),
    .o_sample_data (sample)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge ref_clk);
    wr_s <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1 chk(rdata, e);
    @(posedge ref_clk);
  endtask

  // one trigger, optional second trigger mid-conversion, counts end pulses
  task automatic conv(input logic [9:0] lv, input logic retrig, input int exp_hits);
    int hits;
    int first;
    hits = 0;
    first = 0;
    level <= lv;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    for (int i = 1; i <= 70; i++) begin
      @(posedge ref_clk);
      fire <= retrig && (i == 10);
      #1;
      if (cei === 1'b1) begin
        hits++;
        if (first == 0) first = i;
      end
    end
    chk(hits, exp_hits);
    if (exp_hits == 1) chk(first >= 26 && first <= 32, 1);
    @(posedge ref_clk);
  endtask

  initial begin
    sys_rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    fire = 1'b0;
    level = 10'h000;
    failures = 0;
    checks = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd_chk(ADDR_MODULE_STOP, 32'h1);
    wr(ADDR_CONV_CONTROL, cfg);
    rd_chk(ADDR_CONV_CONTROL, 32'h0);
    wr(ADDR_CONV_CTRL_STATUS, ctl);
    rd_chk(ADDR_CONV_CTRL_STATUS, 32'h0);
    wr(ADDR_MODULE_STOP, 32'h0);
    rd_chk(ADDR_MODULE_STOP, 32'h1);
    wr(ADDR_WRITE_PROTECT, {16'h0, PROT_KEY_OPEN});
    wr(ADDR_MODULE_STOP, 32'h0);
    wr(ADDR_WRITE_PROTECT, {16'h0, PROT_KEY_CLOSE});
    wr(ADDR_MODULE_STOP, 32'h1);
    rd_chk(ADDR_MODULE_STOP, 32'h0);
    wr(ADDR_CONV_CONTROL, cfg);
    rd_chk(ADDR_CONV_CONTROL, cfg);
    wr(ADDR_CONV_CONTROL_TWO, 32'h1);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    wr(ADDR_CONV_CTRL_STATUS, ctl);
    rd_chk(8'h3c, 32'h0);
    chk(chan, CH_AN0);
    conv(10'h2b5, 1'b0, 1);
    rd_chk(ADDR_RESULT_A, {16'h0, 10'h2b5, 6'h0});
    rd_chk(ADDR_IRQ_STATUS, 32'h1);
    chk(irq, 1'b1);
    wr(ADDR_IRQ_ENABLE, 32'h0);
    #1 chk(irq, 1'b0);
    @(posedge ref_clk);
    wr(ADDR_IRQ_CLEAR, 32'h1);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    #1 chk(irq, 1'b0);
    @(posedge ref_clk);
    rd_chk(ADDR_IRQ_STATUS, 32'h0);
    conv(10'h14a, 1'b1, 1);
    rd_chk(ADDR_RESULT_A, {16'h0, 10'h14a, 6'h0});
    wr(ADDR_IRQ_CLEAR, 32'h1);
    wr(ADDR_CONV_CTRL_STATUS, ctl_noie);
    conv(10'h3c3, 1'b0, 0);
    rd_chk(ADDR_RESULT_A, {16'h0, 10'h3c3, 6'h0});
    wr(ADDR_IRQ_CLEAR, 32'h1);
    wr(ADDR_CONV_CTRL_STATUS, 32'h0);
    conv(10'h0f1, 1'b0, 0);
    rd_chk(ADDR_RESULT_A, {16'h0, 10'h3c3, 6'h0});
    wr(ADDR_CONV_CTRL_STATUS, ctl | 32'h5);
    chk(chan, 32'h5);
    conv(10'h0f1, 1'b0, 1);
    rd_chk(ADDR_RESULT_A, {16'h0, 10'h3c3, 6'h0});
    wr(ADDR_CONV_CONTROL_TWO, 32'h0);
    wr(ADDR_CONV_CTRL_STATUS, ctl);
    conv(10'h0f1, 1'b0, 1);
    rd_chk(ADDR_RESULT_A, {22'h0, 10'h0f1});
    wr(ADDR_CONV_CTRL_STATUS, 32'h0);
    wr(ADDR_CONV_CONTROL, (cfg & ~(32'h7 << TRIGGER_SOURCE_SELECT_LSB)) | ({29'h0, TRIGGER_SOURCE_SELECT_SW} << TRIGGER_SOURCE_SELECT_LSB));
    level <= 10'h155;
    wr(ADDR_CONV_CTRL_STATUS, ctl);
    repeat (30) @(posedge ref_clk);
    rd_chk(ADDR_RESULT_A, {22'h0, 10'h155});
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd_chk(ADDR_MODULE_STOP, 32'h1);
    rd_chk(ADDR_CONV_CONTROL, 32'h0);
    rd_chk(ADDR_RESULT_A, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
